// ---- bxc_ctrl.sv ----
// control-pin front end: pin decode, driver enables, status pin, host port select
// assumes analog sensing gives thermometer comparators for four-level pins
// and that the core supplies lock, carrier, interrupt and read data levels
//
// Notes on behaviour
// RQ1 - host output select low enables host driver; high or pulled-up keeps it off
// RQ2 - direction select low means equalizer mode, high means cable-driver mode
// RQ3 - second line select low enables second driver; high keeps it off
// RQ4 - enable high runs normally; low forces power-down
// RQ5 - status pin open-drain, pulled low while the reclocker is locked
// RQ6 - status source selectable: lock, carrier detect or interrupt, still active low
// RQ7 - mode pin floating selects serial peripheral port, resistor-to-ground selects SMBus
// RQ8 - serial peripheral frames accepted only while target select is low
// RQ9 - controller clocks and sends command data; target returns read data
// RQ10 - two address straps sampled after power-up select one of sixteen addresses
// RQ11 - SMBus data is open-drain two-way; clock is driven by the controller
// RQ12 - routing pin independently bypasses reclocker and cable equalizer
// RQ13 - amplitude pin selects one of four levels for both line drivers
// RQ14 - host eq pin sets output shaping in equalizer mode, input eq otherwise
// RQ15 - in equalizer mode the enabled second output carries the loop-through copy
// RQ16 - each four-level pin resolves to a two-bit level code
// RQ17 - shared pins follow the mode; straps used only in SMBus mode
`timescale 1ns/10ps
module bxc_ctrl #(
	// value arbitrary, first address of the strap-selected range
	parameter logic [6:0] SMB_ADDR_BASE = 7'h10
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// two-level control pins
	input wire logic host_out_enable_n_i,
	input wire logic direction_select_i,
	input wire logic second_line_out_enable_n_i,
	input wire logic enable_i,
	// four-level pin comparators
	input wire logic [2:0] route_cmp_i,
	input wire logic [2:0] line_amplitude_select_i,
	input wire logic [2:0] host_eq_level_i,
	input wire logic [2:0] mode_cmp_i,
	// shared serial pins
	input wire logic [2:0] pin_sel_cmp_i,
	input wire logic pin_data_i,
	output logic pin_data_o,
	output logic pin_data_oe_o,
	input wire logic [2:0] pin_aux_cmp_i,
	output logic pin_aux_o,
	output logic pin_aux_oe_o,
	input wire logic sck_i,
	output logic pin_clk_o,
	output logic pin_clk_oe_o,
	// status sources and status pin
	input wire logic cdr_lock_i,
	input wire logic carrier_detect_n_i,
	input wire logic irq_i,
	input wire logic [1:0] status_src_sel_i,
	output logic lock_n_o,
	output logic lock_n_oe_o,
	// core side of the host port
	input wire logic [7:0] spi_rd_data_i,
	input wire logic smb_sda_pull_i,
	output logic spi_wr_valid_o,
	output bxc_pkg::bxc_spi_wr_s spi_wr_o,
	output logic spi_mode_o,
	output logic smb_mode_o,
	output logic smb_scl_o,
	output logic smb_sda_o,
	output logic smb_addr_valid_o,
	output logic [6:0] smb_addr_o,
	// analog controls
	output logic cd_mode_o,
	output logic power_down_o,
	output logic host_out_drv_en_o,
	output logic second_line_drv_en_o,
	output logic loop_through_en_o,
	output logic reclk_bypass_o,
	output logic eq_bypass_o,
	output logic [1:0] amp_code_o,
	output logic [1:0] host_out_eq_o,
	output logic [1:0] host_in_eq_o,
	output bxc_pkg::bxc_lvl_s lvl_o
);

	////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic [9:0] pin_raw;
	logic [9:0] pin_s;
	logic [17:0] lvl_raw;
	logic [17:0] lvl_s;
	logic host_n_s;
	logic dir_s;
	logic second_n_s;
	logic en_s;
	logic lock_s;
	logic cd_n_s;
	logic scl_s;
	logic sda_s;
	logic ss_n_s;
	logic wr_tgl_s;

	logic spi_miso;
	logic spi_tgl;
	bxc_pkg::bxc_spi_wr_s spi_word;

	assign pin_raw = {spi_tgl, pin_sel_cmp_i[2], pin_data_i, sck_i, carrier_detect_n_i,
		cdr_lock_i, enable_i, second_line_out_enable_n_i, direction_select_i,
		host_out_enable_n_i};
	assign lvl_raw = {route_cmp_i, line_amplitude_select_i, host_eq_level_i, mode_cmp_i,
		pin_sel_cmp_i, pin_aux_cmp_i};
	assign {wr_tgl_s, ss_n_s, sda_s, scl_s, cd_n_s, lock_s, en_s, second_n_s, dir_s,
		host_n_s} = pin_s;

	bxc_sync #(.W(10), .RST_VAL(bxc_pkg::PIN_SYNC_RST)) u_pin_sync (
		.clk_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	bxc_sync #(.W(18), .RST_VAL(bxc_pkg::LVL_SYNC_RST)) u_lvl_sync (
		.clk_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(lvl_raw),
		.q_o(lvl_s)
	);

	////////////////////////////////////////////////////////////////////////
	// four-level decode

	bxc_pkg::bxc_lvl_s next_lvl;

	always_comb begin
		next_lvl.route = bxc_pkg::lvl_decode(lvl_s[17:15]); // RQ16
		next_lvl.amp = bxc_pkg::lvl_decode(lvl_s[14:12]);
		next_lvl.host_eq = bxc_pkg::lvl_decode(lvl_s[11:9]);
		next_lvl.mode = bxc_pkg::lvl_decode(lvl_s[8:6]);
		next_lvl.strap_lo = bxc_pkg::lvl_decode(lvl_s[5:3]);
		next_lvl.strap_hi = bxc_pkg::lvl_decode(lvl_s[2:0]);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			lvl_o <= '0;
		else
			lvl_o <= next_lvl; // RQ16
	end

	////////////////////////////////////////////////////////////////////////
	// direction, power and driver enables

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cd_mode_o <= bxc_pkg::RST_CD_MODE;
			power_down_o <= bxc_pkg::RST_POWER_DOWN;
		end else begin
			cd_mode_o <= dir_s; // RQ2
			power_down_o <= !en_s; // RQ4
		end
	end

	// drivers stay off in power-down whatever their select pins say
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			host_out_drv_en_o <= bxc_pkg::RST_DRV_EN;
			second_line_drv_en_o <= bxc_pkg::RST_DRV_EN;
			loop_through_en_o <= bxc_pkg::RST_DRV_EN;
		end else begin
			host_out_drv_en_o <= !host_n_s && en_s; // RQ1
			second_line_drv_en_o <= !second_n_s && en_s; // RQ3
			loop_through_en_o <= !second_n_s && en_s && !dir_s; // RQ15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// routing, amplitude and host equalisation

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reclk_bypass_o <= 1'b0;
			eq_bypass_o <= 1'b0;
			amp_code_o <= bxc_pkg::LVL_LOW;
		end else begin
			reclk_bypass_o <= next_lvl.route[bxc_pkg::ROUTE_RECLK_BYP_BIT]; // RQ12
			eq_bypass_o <= next_lvl.route[bxc_pkg::ROUTE_EQ_BYP_BIT]; // RQ12
			amp_code_o <= next_lvl.amp; // RQ13
		end
	end

	// the unused half parks at the lowest code
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			host_out_eq_o <= bxc_pkg::LVL_LOW;
			host_in_eq_o <= bxc_pkg::LVL_LOW;
		end else begin
			host_out_eq_o <= dir_s ? bxc_pkg::LVL_LOW : next_lvl.host_eq; // RQ14
			host_in_eq_o <= dir_s ? next_lvl.host_eq : bxc_pkg::LVL_LOW; // RQ14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status pin

	logic next_status_active;

	always_comb begin
		case (status_src_sel_i)
			bxc_pkg::STS_CARRIER: next_status_active = !cd_n_s; // RQ6
			bxc_pkg::STS_IRQ: next_status_active = irq_i; // RQ6
			default: next_status_active = lock_s; // RQ5
		endcase
	end

	assign lock_n_o = 1'b0;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			lock_n_oe_o <= 1'b0;
		else
			lock_n_oe_o <= next_status_active; // RQ5
	end

	////////////////////////////////////////////////////////////////////////
	// host port mode and shared pins

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			spi_mode_o <= 1'b0;
			smb_mode_o <= 1'b0;
		end else begin
			spi_mode_o <= next_lvl.mode == bxc_pkg::LVL_FLOAT; // RQ7
			smb_mode_o <= next_lvl.mode == bxc_pkg::LVL_RGND; // RQ7
		end
	end

	// data pin: open-drain only in SMBus mode, input-only otherwise
	assign pin_data_o = 1'b0;
	assign pin_data_oe_o = smb_mode_o && smb_sda_pull_i; // RQ11
	// clock pin is never driven by this end
	assign pin_clk_o = 1'b0;
	assign pin_clk_oe_o = 1'b0;
	// aux pin carries read data only while selected in serial peripheral mode
	assign pin_aux_o = spi_miso;
	assign pin_aux_oe_o = spi_mode_o && !pin_sel_cmp_i[2]; // RQ17

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			smb_scl_o <= 1'b1;
			smb_sda_o <= 1'b1;
		end else begin
			smb_scl_o <= smb_mode_o ? scl_s : 1'b1; // RQ17
			smb_sda_o <= smb_mode_o ? sda_s : 1'b1; // RQ11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial peripheral target and word crossing

	logic [7:0] rd_hold;
	logic wr_tgl_d;
	logic wr_edge;

	// read byte only moves while deselected, so the link side sees it still
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			rd_hold <= 8'h00;
		else if (ss_n_s)
			rd_hold <= spi_rd_data_i;
	end

	bxc_spi_target u_spi (
		.sck_i(sck_i),
		.rst_i(rst_i),
		.ss_n_i(pin_sel_cmp_i[2]),
		.mosi_i(pin_data_i),
		.miso_o(spi_miso),
		.rd_byte_i(rd_hold),
		.wr_word_o(spi_word),
		.wr_toggle_o(spi_tgl)
	);

	assign wr_edge = wr_tgl_s ^ wr_tgl_d;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_tgl_d <= 1'b0;
			spi_wr_valid_o <= 1'b0;
			spi_wr_o <= '0;
		end else begin
			wr_tgl_d <= wr_tgl_s;
			spi_wr_valid_o <= wr_edge && spi_mode_o; // RQ8
			if (wr_edge && spi_mode_o)
				spi_wr_o <= spi_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address straps, caught once after reset release

	bxc_pkg::bxc_strap_e strap_st;
	logic [3:0] settle_cnt;
	logic [3:0] strap_idx;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			strap_st <= bxc_pkg::STRAP_SETTLE;
			settle_cnt <= 4'h0;
			strap_idx <= bxc_pkg::RST_STRAP_IDX;
		end else begin
			case (strap_st)
				bxc_pkg::STRAP_SETTLE: begin
					settle_cnt <= 4'(settle_cnt + 4'h1);
					if (settle_cnt == bxc_pkg::STRAP_SETTLE_LAST)
						strap_st <= bxc_pkg::STRAP_CAPTURE;
				end
				bxc_pkg::STRAP_CAPTURE: begin
					strap_idx <= {next_lvl.strap_hi, next_lvl.strap_lo}; // RQ10
					strap_st <= bxc_pkg::STRAP_DONE;
				end
				bxc_pkg::STRAP_DONE: strap_st <= bxc_pkg::STRAP_DONE;
				default: strap_st <= bxc_pkg::STRAP_SETTLE;
			endcase
		end
	end

	assign smb_addr_valid_o = strap_st == bxc_pkg::STRAP_DONE && smb_mode_o; // RQ17
	assign smb_addr_o = 7'(SMB_ADDR_BASE + {3'h0, strap_idx}); // RQ10

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	sequence s_capture;
		strap_st == bxc_pkg::STRAP_CAPTURE;
	endsequence

	sequence s_done_hold;
		(strap_st == bxc_pkg::STRAP_DONE)[*3];
	endsequence

	host_drv_gate_a: assert property (host_n_s |=> !host_out_drv_en_o) // RQ1
		else $error("host driver on while its select is high");
	host_drv_on_a: assert property (!host_n_s && en_s |=> host_out_drv_en_o) // RQ1
		else $error("host driver not enabled");
	dir_mode_a: assert property (##1 cd_mode_o == $past(dir_s)) // RQ2
		else $error("direction mode does not follow pin");
	second_drv_a: assert property (second_n_s |=> !second_line_drv_en_o) // RQ3
		else $error("second driver on while its select is high");
	power_down_a: assert property (!en_s |=> power_down_o && !host_out_drv_en_o
		&& !second_line_drv_en_o) // RQ4
		else $error("power-down not applied");
	status_lock_a: assert property (status_src_sel_i == bxc_pkg::STS_LOCK
		|=> lock_n_oe_o == $past(lock_s)) // RQ5
		else $error("status pin does not show lock");
	status_irq_a: assert property (status_src_sel_i == bxc_pkg::STS_IRQ && irq_i
		|=> lock_n_oe_o && !lock_n_o) // RQ6
		else $error("status pin does not show interrupt");
	status_cd_a: assert property (status_src_sel_i == bxc_pkg::STS_CARRIER
		|=> lock_n_oe_o == !$past(cd_n_s)) // RQ6
		else $error("status pin does not show carrier");
	mode_sel_a: assert property (next_lvl.mode == bxc_pkg::LVL_FLOAT
		|=> spi_mode_o && !smb_mode_o) // RQ7
		else $error("floating mode pin did not select serial peripheral");
	spi_accept_a: assert property (spi_wr_valid_o |-> $past(spi_mode_o)) // RQ8
		else $error("write accepted outside serial peripheral mode");
	strap_take_a: assert property (s_capture |=> s_done_hold
		and strap_idx == {lvl_o.strap_hi, lvl_o.strap_lo}) // RQ10
		else $error("address straps not captured");
	strap_time_a: assert property ($rose(strap_st == bxc_pkg::STRAP_CAPTURE)
		|-> $past(settle_cnt) == bxc_pkg::STRAP_SETTLE_LAST) // RQ10
		else $error("straps captured before settling");
	sda_drive_a: assert property (!smb_mode_o |-> !pin_data_oe_o && !pin_clk_oe_o) // RQ11
		else $error("data pin driven outside SMBus mode");
	route_a: assert property (##1 {eq_bypass_o, reclk_bypass_o} == $past(next_lvl.route)) // RQ12
		else $error("routing bits do not follow pin");
	host_eq_a: assert property (dir_s |=> host_out_eq_o == bxc_pkg::LVL_LOW
		&& host_in_eq_o == $past(next_lvl.host_eq)) // RQ14
		else $error("host eq not steered to input side");
	loop_a: assert property (loop_through_en_o |-> second_line_drv_en_o && !cd_mode_o) // RQ15
		else $error("loop-through without equalizer mode");

endmodule

// ---- bxc_pkg.sv ----
// shared constants, types and decode helpers of the control-pin front end
// assumes four-level pins arrive as three thermometer comparator outputs each
package bxc_pkg;

	// resolved level codes of a four-level pin
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_RGND = 2'h1;
	localparam logic [1:0] LVL_FLOAT = 2'h2;
	localparam logic [1:0] LVL_HIGH = 2'h3;

	// comparator patterns, thermometer coded
	localparam logic [2:0] CMP_HIGH = 3'h7;
	localparam logic [2:0] CMP_FLOAT = 3'h3;
	localparam logic [2:0] CMP_RGND = 3'h1;

	// status output source selection
	localparam logic [1:0] STS_LOCK = 2'h0;
	localparam logic [1:0] STS_CARRIER = 2'h1;
	localparam logic [1:0] STS_IRQ = 2'h2;

	// routing code field positions
	localparam int ROUTE_RECLK_BYP_BIT = 0;
	localparam int ROUTE_EQ_BYP_BIT = 1;

	// serial frame: read flag, 7 address bits, 8 data bits
	localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
	localparam logic [4:0] SPI_DATA_FIRST = 5'h08;

	// synchroniser reset values, pins that idle high reset high
	localparam logic [9:0] PIN_SYNC_RST = 10'h1ed;
	localparam logic [17:0] LVL_SYNC_RST = 18'h00000;

	// strap settling delay after reset release
	localparam int CLK_PERIOD_NS = 8;
	localparam int STRAP_SETTLE_NS = 64;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] STRAP_SETTLE_LAST = 4'(STRAP_SETTLE_CYC - 1);

	// output reset values
	localparam logic RST_CD_MODE = 1'b0;
	localparam logic RST_POWER_DOWN = 1'b0;
	localparam logic RST_DRV_EN = 1'b0;
	localparam logic [3:0] RST_STRAP_IDX = 4'h0;

	typedef enum logic [2:0] {
		STRAP_SETTLE = 3'b001,
		STRAP_CAPTURE = 3'b010,
		STRAP_DONE = 3'b100
	} bxc_strap_e;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} bxc_spi_wr_s;

	typedef struct packed {
		logic [1:0] route;
		logic [1:0] amp;
		logic [1:0] host_eq;
		logic [1:0] mode;
		logic [1:0] strap_lo;
		logic [1:0] strap_hi;
	} bxc_lvl_s;

	function automatic logic [1:0] lvl_decode(input logic [2:0] cmp);
		case (cmp)
			CMP_HIGH: lvl_decode = LVL_HIGH;
			CMP_FLOAT: lvl_decode = LVL_FLOAT;
			CMP_RGND: lvl_decode = LVL_RGND;
			default: lvl_decode = LVL_LOW;
		endcase
	endfunction

endpackage

// ---- bxc_sync.sv ----
// two-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level, never a multi-bit word
`timescale 1ns/10ps
module bxc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule

// ---- bxc_spi_target.sv ----
// serial target on the controller's clock: 16-bit frames, read flag first
// assumes rd_byte_i holds still while the target is selected
`timescale 1ns/10ps
module bxc_spi_target (
	// link clock and resets
	input wire logic sck_i,
	input wire logic rst_i,
	input wire logic ss_n_i,
	// serial data
	input wire logic mosi_i,
	output logic miso_o,
	// word hand-off
	input wire logic [7:0] rd_byte_i,
	output bxc_pkg::bxc_spi_wr_s wr_word_o,
	output logic wr_toggle_o
);

	logic frame_rst;
	logic [4:0] bit_cnt;
	logic [14:0] shift;
	logic rd_flag;
	logic [3:0] rd_idx;

	// deselect ends the frame without needing further clock edges
	assign frame_rst = rst_i | ss_n_i;
	assign rd_idx = 4'hf - bit_cnt[3:0];

	always_ff @(posedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt <= 5'h00;
			shift <= 15'h0000;
			rd_flag <= 1'b0;
		end else begin
			shift <= {shift[13:0], mosi_i};
			if (bit_cnt != bxc_pkg::SPI_FRAME_BITS)
				bit_cnt <= 5'(bit_cnt + 5'h01);
			if (bit_cnt == 5'h00)
				rd_flag <= mosi_i;
		end
	end

	// word held until the next complete write frame
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			wr_word_o <= '0;
			wr_toggle_o <= 1'b0;
		end else if (!ss_n_i && bit_cnt == 5'h0f && !rd_flag) begin
			wr_word_o <= {shift[13:0], mosi_i};
			wr_toggle_o <= ~wr_toggle_o;
		end
	end

	// read data changes on the falling edge for the controller's rising edge
	always_ff @(negedge sck_i or posedge frame_rst) begin
		if (frame_rst)
			miso_o <= 1'b0;
		else if (rd_flag && bit_cnt >= bxc_pkg::SPI_DATA_FIRST
				&& bit_cnt != bxc_pkg::SPI_FRAME_BITS)
			miso_o <= rd_byte_i[rd_idx[2:0]]; // RQ9
		else
			miso_o <= 1'b0;
	end

endmodule

// ---- bxc_host_model.sv ----
// host controller model driving the serial peripheral pins of the front end
// assumes the bench routes these pins onto the shared device pins in that mode
`timescale 1ns/10ps
module bxc_host_model (
	// serial pins
	output logic sck_o,
	output logic ss_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b1;
	end

	// clock stands low between frames; nbits under 16 gives a short frame
	task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		#5;
		ss_n_o = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi_o = word[15 - i];
			#24 sck_o = 1'b1;
			if (i >= 8)
				rx[15 - i] = miso_i;
			#24 sck_o = 1'b0;
		end
		#24 ss_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask
endmodule

// ---- bxc_ctrl_bench.sv ----
// self-checking bench of the control-pin front end
// assumes bxc_pkg, bxc_sync, bxc_spi_target, bxc_ctrl and bxc_host_model compile first
`timescale 1ns/10ps
module bxc_ctrl_bench;
	typedef struct packed {
		logic [3:0] pins;
		logic [2:0] rt;
		logic [2:0] am;
		logic [2:0] he;
		logic [1:0] sel;
		logic [2:0] st_in;
		logic [4:0] exp_drv;
		logic exp_st;
	} bxc_row_s;
	localparam logic [6:0] ADDR_BASE = 7'h20;
	// pins {host_n, dir, sec_n, en}, st_in {lock, cd_n, irq}
	// exp_drv {host drv, cd mode, second drv, power down, loop-through}
	bxc_row_s rows [6] = '{
		'{4'hb, 3'h7, 3'h3, 3'h1, 2'h0, 3'b110, 5'b00000, 1'b1},
		'{4'h3, 3'h3, 3'h1, 3'h7, 2'h1, 3'b000, 5'b10000, 1'b1},
		'{4'h9, 3'h1, 3'h0, 3'h3, 2'h2, 3'b011, 5'b00101, 1'b1},
		'{4'h5, 3'h0, 3'h7, 3'h1, 2'h3, 3'b100, 5'b11100, 1'b1},
		'{4'h0, 3'h5, 3'h3, 3'h7, 2'h2, 3'b100, 5'b00010, 1'b0},
		'{4'hb, 3'h7, 3'h1, 3'h3, 2'h1, 3'b111, 5'b00000, 1'b0}};
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] pins = 4'hb;
	logic [2:0] rt = 3'h0;
	logic [2:0] am = 3'h0;
	logic [2:0] he = 3'h0;
	logic [2:0] mode = 3'h3;
	logic [2:0] strap_lo = 3'h7;
	logic [2:0] strap_hi = 3'h7;
	logic [1:0] sel = 2'h0;
	logic [2:0] st_in = 3'b010;
	logic [7:0] rd_data = 8'h00;
	logic sda_pull = 1'b0;
	logic ctl_scl = 1'b1;
	logic [7:0] wr_cnt = 8'h00;
	logic [7:0] rx;
	logic [1:0] c_rt, c_am, c_he;
	int err_total = 0;
	int total_checks = 0;
	wire sck, ss_n, mosi;
	wire pin_data_o, pin_data_oe_o, pin_aux_o, pin_aux_oe_o, pin_clk_o, pin_clk_oe_o;
	wire lock_n_o, lock_n_oe, wr_valid, spi_mode, smb_mode, smb_scl, smb_sda, addr_valid;
	wire cd, pd, host_drv, sec_drv, loop, rbyp, ebyp;
	wire [6:0] smb_addr;
	wire [1:0] amp, heo, hei;
	bxc_pkg::bxc_spi_wr_s spi_wr;
	bxc_pkg::bxc_lvl_s lvl;
	// shared pins: bus wires resolved from every party's drive
	wire smb = (mode == 3'h1);
	wire sda_w = ~pin_data_oe_o;
	wire miso_w = pin_aux_oe_o ? pin_aux_o : 1'b1;
	wire [2:0] sel_w = smb ? strap_lo : {ss_n, 2'b11};
	wire [2:0] aux_w = smb ? strap_hi : {3{miso_w}};

	initial forever #4 clk_sys_i = ~clk_sys_i;

	bxc_host_model u_host (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso_w));

	bxc_ctrl #(.SMB_ADDR_BASE(ADDR_BASE)) u_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.host_out_enable_n_i(pins[3]), .direction_select_i(pins[2]),
		.second_line_out_enable_n_i(pins[1]), .enable_i(pins[0]),
		.route_cmp_i(rt), .line_amplitude_select_i(am), .host_eq_level_i(he),
		.mode_cmp_i(mode), .pin_sel_cmp_i(sel_w), .pin_data_i(smb ? sda_w : mosi),
		.pin_data_o(pin_data_o), .pin_data_oe_o(pin_data_oe_o), .pin_aux_cmp_i(aux_w),
		.pin_aux_o(pin_aux_o), .pin_aux_oe_o(pin_aux_oe_o), .sck_i(smb ? ctl_scl : sck),
		.pin_clk_o(pin_clk_o), .pin_clk_oe_o(pin_clk_oe_o), .cdr_lock_i(st_in[2]),
		.carrier_detect_n_i(st_in[1]), .irq_i(st_in[0]), .status_src_sel_i(sel),
		.lock_n_o(lock_n_o), .lock_n_oe_o(lock_n_oe), .spi_rd_data_i(rd_data),
		.smb_sda_pull_i(sda_pull), .spi_wr_valid_o(wr_valid), .spi_wr_o(spi_wr),
		.spi_mode_o(spi_mode), .smb_mode_o(smb_mode), .smb_scl_o(smb_scl),
		.smb_sda_o(smb_sda), .smb_addr_valid_o(addr_valid), .smb_addr_o(smb_addr),
		.cd_mode_o(cd), .power_down_o(pd), .host_out_drv_en_o(host_drv),
		.second_line_drv_en_o(sec_drv), .loop_through_en_o(loop), .reclk_bypass_o(rbyp),
		.eq_bypass_o(ebyp), .amp_code_o(amp), .host_out_eq_o(heo), .host_in_eq_o(hei),
		.lvl_o(lvl));

	always @(posedge clk_sys_i)
		if (wr_valid === 1'b1)
			wr_cnt <= wr_cnt + 8'h01;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [1:0] code_of(input logic [2:0] c);
		return (c == 3'h7) ? 2'h3 : (c == 3'h3) ? 2'h2 : (c == 3'h1) ? 2'h1 : 2'h0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// straps are taken after release, so every mode change goes through reset
	task automatic do_reset(input logic [2:0] m, input logic [2:0] lo, input logic [2:0] hi);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		mode <= m;
		strap_lo <= lo;
		strap_hi <= hi;
		@(negedge clk_sys_i);
		chk({host_drv, sec_drv, loop, lock_n_oe, wr_valid, smb_scl, addr_valid}, 7'h02);
		@(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (14) @(posedge clk_sys_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(3'h3, 3'h7, 3'h7);
		foreach (rows[i]) begin
			@(posedge clk_sys_i);
			pins <= rows[i].pins;
			{rt, am, he, sel, st_in} <= {rows[i].rt, rows[i].am, rows[i].he, rows[i].sel, rows[i].st_in};
			c_rt = code_of(rows[i].rt);
			c_am = code_of(rows[i].am);
			c_he = code_of(rows[i].he);
			repeat (5) @(posedge clk_sys_i);
			#1;
			chk({host_drv, cd, sec_drv, pd, loop}, rows[i].exp_drv);
			chk({lock_n_oe, lock_n_o}, {rows[i].exp_st, 1'b0});
			chk({ebyp, rbyp}, c_rt);
			chk(amp, c_am);
			chk({heo, hei}, rows[i].pins[2] ? {2'h0, c_he} : {c_he, 2'h0});
			chk({lvl.route, lvl.amp, lvl.host_eq}, {c_rt, c_am, c_he});
		end
		// serial port: write, read, aborted frame, then a write again
		chk({spi_mode, smb_mode, pin_aux_oe_o}, 3'b100);
		u_host.xfer(16'h5ac3, 16, rx);
		repeat (10) @(posedge clk_sys_i);
		chk({wr_cnt, spi_wr}, {8'h01, 7'h5a, 8'hc3});
		rd_data <= 8'ha5;
		u_host.xfer(16'h9100, 16, rx);
		chk(rx, 8'ha5);
		u_host.xfer(16'h3377, 8, rx);
		u_host.xfer(16'h7f01, 16, rx);
		repeat (10) @(posedge clk_sys_i);
		chk({wr_cnt, spi_wr}, {8'h02, 7'h7f, 8'h01});
		// smbus with straps float and resistor-to-ground
		do_reset(3'h1, 3'h3, 3'h1);
		chk({spi_mode, smb_mode, addr_valid, smb_addr}, {3'b011, ADDR_BASE + 7'h06});
		@(posedge clk_sys_i);
		sda_pull <= 1'b1;
		ctl_scl <= 1'b0;
		#1;
		chk({pin_data_oe_o, pin_data_o, pin_clk_oe_o}, 3'b100);
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk({smb_scl, smb_sda}, 2'b00);
		@(posedge clk_sys_i);
		sda_pull <= 1'b0;
		ctl_scl <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk({pin_data_oe_o, smb_scl, smb_sda}, 3'b011);
		// mode pin low selects neither port
		do_reset(3'h0, 3'h3, 3'h1);
		chk({spi_mode, smb_mode, addr_valid}, 3'b000);
		end_sim();
	end

	initial begin
		#100000;
		err_total++;
		end_sim();
	end
endmodule
